// ### inc/utr_pkg.sv
// package for the uart threshold, rate and rs-485 turn-around control block
package utr_pkg;
   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_TX_LVL = 8'h00;
   localparam logic [7:0] ADDR_RX_LVL = 8'h04;
   localparam logic [7:0] ADDR_FLW_HI = 8'h08;
   localparam logic [7:0] ADDR_FLW_LO = 8'h0c;
   localparam logic [7:0] ADDR_PRESC = 8'h10;
   localparam logic [7:0] ADDR_SAMP_RATE = 8'h14;
   localparam logic [7:0] ADDR_TURN = 8'h18;
   localparam logic [7:0] ADDR_CTRL = 8'h1c;
   localparam logic [7:0] ADDR_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int CTRL_MODE_485 = 0;
   localparam int CTRL_DIR_DTR = 1;
   localparam int CTRL_FIFO128 = 2;
   localparam logic [7:0] RST_LVL = 8'h00;
   localparam logic [7:0] LVL_MAX = 8'h80;
   localparam logic [7:0] LVL_MIN = 8'h01;
   localparam logic [3:0] PRESC_MASK = 4'hf;
   localparam logic [1:0] SAMP_16X = 2'b00;
   localparam logic [1:0] SAMP_8X = 2'b01;
   localparam logic [1:0] SAMP_4X = 2'b10;
   localparam int EV_TX = 0;
   localparam int EV_RX = 1;
   localparam int EV_FLOW_STOP = 2;
   localparam int EV_TURN_DONE = 3;
   localparam int NUM_EV = 4;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TS_IDLE = 2'b00,
      TS_DRIVE = 2'b01,
      TS_COUNT = 2'b11
   } utr_turn_t;
endpackage : utr_pkg

// ### rtl/utr_ctrl.sv
// uart threshold, sampling rate and rs-485 turn-around control
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
module utr_ctrl #(
   parameter int FILL_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hsel,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [FILL_W-1:0] tx_fill,
   input wire logic [FILL_W-1:0] rx_fill,
   input wire logic [1:0] fifo_ctrl_tx_trig,
   input wire logic [1:0] fifo_ctrl_rx_trig,
   input wire logic tx_active,
   input wire logic tx_shift_done,
   input wire logic bit_tick,
   output logic tx_irq_req,
   output logic rx_irq_req,
   output logic flow_stop_remote,
   output logic [3:0] clock_prescale,
   output logic [1:0] sample_rate,
   output logic rs485_mode,
   output logic request_to_send_pin,
   output logic terminal_ready_pin,
   output logic irq
);
   typedef struct packed {
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic [7:0] tx_lvl;
      logic [7:0] rx_lvl;
      logic [7:0] flw_hi;
      logic [7:0] flw_lo;
      logic [3:0] presc;
      logic [1:0] samp_sel;
      logic [7:0] turn;
      logic [2:0] ctrl;
      logic [7:0] cnt;
      utr_pkg::utr_turn_t tstate;
      logic flow_stop;
      logic [utr_pkg::NUM_EV-1:0] ists;
      logic [utr_pkg::NUM_EV-1:0] imask;
      logic [31:0] rdata;
      logic txi;
      logic rxi;
      logic dir_n;
   } utr_state_t;

   utr_state_t s_ff;
   utr_state_t nxt_s;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] utr_level(input logic [7:0] raw);
      if (raw < utr_pkg::LVL_MIN) begin
         return utr_pkg::LVL_MIN;
      end else if (raw > utr_pkg::LVL_MAX) begin
         return utr_pkg::LVL_MAX;
      end
      return raw;
   endfunction : utr_level

   // 32-byte mode trigger table from fifo control field
   function automatic logic [7:0] utr_fifo_ctrl_level(input logic [1:0] code);
      case (code)
         2'b00: return 8'h08;
         2'b01: return 8'h10;
         2'b10: return 8'h18;
         default: return 8'h1c;
      endcase
   endfunction : utr_fifo_ctrl_level

   function automatic logic [7:0] utr_fill8(input logic [FILL_W-1:0] f);
      return 8'(f);
   endfunction : utr_fill8

   logic [7:0] tx_thr;
   logic [7:0] rx_thr;
   logic [7:0] hi_thr;
   logic [7:0] lo_thr;
   logic fifo128;
   logic [utr_pkg::NUM_EV-1:0] ev;
   logic txi_now;
   logic rxi_now;

   // ----------------------------------------
   // effective thresholds
   // ----------------------------------------
   always_comb begin
      fifo128 = s_ff.ctrl[utr_pkg::CTRL_FIFO128];
      if (fifo128) begin
         tx_thr = utr_level(s_ff.tx_lvl);
         rx_thr = utr_level(s_ff.rx_lvl);
         hi_thr = utr_level(s_ff.flw_hi);
         lo_thr = utr_level(s_ff.flw_lo);
      end else begin
         tx_thr = utr_fifo_ctrl_level(fifo_ctrl_tx_trig);
         rx_thr = utr_fifo_ctrl_level(fifo_ctrl_rx_trig);
         hi_thr = utr_fifo_ctrl_level(fifo_ctrl_rx_trig);
         lo_thr = utr_fifo_ctrl_level(fifo_ctrl_rx_trig) - 8'h01;
      end
      txi_now = utr_fill8(tx_fill) < tx_thr;
      rxi_now = utr_fill8(rx_fill) >= rx_thr;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_s = s_ff;
      ev = '0;
      nxt_s.txi = txi_now;
      nxt_s.rxi = rxi_now;
      ev[utr_pkg::EV_TX] = txi_now & ~s_ff.txi;
      ev[utr_pkg::EV_RX] = rxi_now & ~s_ff.rxi;
      // flow control with hysteresis between the two thresholds
      if (utr_fill8(rx_fill) >= hi_thr) begin
         nxt_s.flow_stop = 1'b1;
         ev[utr_pkg::EV_FLOW_STOP] = ~s_ff.flow_stop;
      end else if (utr_fill8(rx_fill) <= lo_thr) begin
         nxt_s.flow_stop = 1'b0;
      end
      // turn-around: driver stays on while the countdown runs
      case (s_ff.tstate)
         utr_pkg::TS_IDLE: begin
            nxt_s.dir_n = 1'b0;
            if (s_ff.ctrl[utr_pkg::CTRL_MODE_485] && tx_active) begin
               nxt_s.tstate = utr_pkg::TS_DRIVE;
               nxt_s.dir_n = 1'b1;
            end
         end
         utr_pkg::TS_DRIVE: begin
            if (tx_shift_done) begin
               nxt_s.cnt = s_ff.turn;
               nxt_s.tstate = utr_pkg::TS_COUNT;
            end
         end
         utr_pkg::TS_COUNT: begin
            if (tx_active) begin
               nxt_s.tstate = utr_pkg::TS_DRIVE;
            end else if (s_ff.cnt == 8'h00) begin
               nxt_s.dir_n = 1'b0;
               nxt_s.tstate = utr_pkg::TS_IDLE;
               ev[utr_pkg::EV_TURN_DONE] = 1'b1;
            end else if (bit_tick) begin
               nxt_s.cnt = s_ff.cnt - 8'h01;
            end
         end
         default: begin
            nxt_s.tstate = utr_pkg::TS_IDLE;
            nxt_s.dir_n = 1'b0;
         end
      endcase
      if (!s_ff.ctrl[utr_pkg::CTRL_MODE_485]) begin
         nxt_s.tstate = utr_pkg::TS_IDLE;
         nxt_s.dir_n = 1'b0;
      end
      // bus data phase; read of status clears, but a new event wins
      if (s_ff.wr_pend) begin
         case (s_ff.addr)
            utr_pkg::ADDR_TX_LVL: nxt_s.tx_lvl = hwdata[7:0];
            utr_pkg::ADDR_RX_LVL: nxt_s.rx_lvl = hwdata[7:0];
            utr_pkg::ADDR_FLW_HI: nxt_s.flw_hi = hwdata[7:0];
            utr_pkg::ADDR_FLW_LO: nxt_s.flw_lo = hwdata[7:0];
            utr_pkg::ADDR_PRESC: nxt_s.presc = hwdata[3:0] & utr_pkg::PRESC_MASK;
            utr_pkg::ADDR_SAMP_RATE: nxt_s.samp_sel = hwdata[1:0];
            utr_pkg::ADDR_TURN: nxt_s.turn = hwdata[7:0];
            utr_pkg::ADDR_CTRL: nxt_s.ctrl = hwdata[2:0];
            utr_pkg::ADDR_IRQ_MASK: nxt_s.imask = hwdata[utr_pkg::NUM_EV-1:0];
            default: ;
         endcase
      end
      if (s_ff.rd_pend && s_ff.addr == utr_pkg::ADDR_IRQ_STAT) begin
         nxt_s.ists = ev;
      end else begin
         nxt_s.ists = s_ff.ists | ev;
      end
      // address phase
      nxt_s.wr_pend = hsel && hready && htrans[1] && hwrite;
      nxt_s.rd_pend = hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1]) begin
         nxt_s.addr = haddr[7:0];
      end
      nxt_s.rdata = 32'h0000_0000;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            utr_pkg::ADDR_TX_LVL: nxt_s.rdata = {24'h00_0000, s_ff.tx_lvl};
            utr_pkg::ADDR_RX_LVL: nxt_s.rdata = {24'h00_0000, s_ff.rx_lvl};
            utr_pkg::ADDR_FLW_HI: nxt_s.rdata = {24'h00_0000, s_ff.flw_hi};
            utr_pkg::ADDR_FLW_LO: nxt_s.rdata = {24'h00_0000, s_ff.flw_lo};
            utr_pkg::ADDR_PRESC: nxt_s.rdata = {28'h000_0000, s_ff.presc};
            utr_pkg::ADDR_SAMP_RATE: nxt_s.rdata = {30'h0000_0000, s_ff.samp_sel};
            utr_pkg::ADDR_TURN: nxt_s.rdata = {24'h00_0000, s_ff.turn};
            utr_pkg::ADDR_CTRL: nxt_s.rdata = {29'h0000_0000, s_ff.ctrl};
            utr_pkg::ADDR_STAT: nxt_s.rdata = {16'h0000, s_ff.cnt, 3'h0, s_ff.dir_n,
                                               s_ff.flow_stop, s_ff.rxi, s_ff.txi, 1'b0};
            utr_pkg::ADDR_IRQ_STAT: nxt_s.rdata = {28'h000_0000, s_ff.ists};
            utr_pkg::ADDR_IRQ_MASK: nxt_s.rdata = {28'h000_0000, s_ff.imask};
            default: nxt_s.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= '{wr_pend: 1'b0, rd_pend: 1'b0, addr: 8'h00, tx_lvl: utr_pkg::RST_LVL,
                   rx_lvl: utr_pkg::RST_LVL, flw_hi: utr_pkg::RST_LVL, flw_lo: utr_pkg::RST_LVL,
                   presc: 4'h0, samp_sel: utr_pkg::SAMP_16X, turn: 8'h00, ctrl: 3'h0, cnt: 8'h00,
                   tstate: utr_pkg::TS_IDLE, flow_stop: 1'b0, ists: '0, imask: '0,
                   rdata: 32'h0000_0000, txi: 1'b0, rxi: 1'b0, dir_n: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hrdata = s_ff.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign tx_irq_req = s_ff.txi;
   assign rx_irq_req = s_ff.rxi;
   assign flow_stop_remote = s_ff.flow_stop;
   assign clock_prescale = s_ff.presc;
   // reserved code falls back to 16x
   assign sample_rate = (s_ff.samp_sel == 2'b11) ? utr_pkg::SAMP_16X : s_ff.samp_sel;
   assign rs485_mode = s_ff.ctrl[utr_pkg::CTRL_MODE_485];
   // unselected pin idles low; driving high means transmit
   assign request_to_send_pin = s_ff.dir_n & ~s_ff.ctrl[utr_pkg::CTRL_DIR_DTR];
   assign terminal_ready_pin = s_ff.dir_n & s_ff.ctrl[utr_pkg::CTRL_DIR_DTR];
   assign irq = |(s_ff.ists & s_ff.imask);
endmodule : utr_ctrl

// ### sim/testbench.sv
// testbench for the threshold, rate and turn-around block
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, start = 1'b0, hready, hresp, tx_active, tx_shift_done;
   logic bit_tick, tx_irq_req, rx_irq_req, flow_stop_remote, rs485_mode, irq;
   logic request_to_send_pin, terminal_ready_pin;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = '0, fifo_ctrl_tx_trig = '0, fifo_ctrl_rx_trig = '0, sample_rate;
   logic [7:0] tx_fill = '0, rx_fill = '0;
   logic [3:0] clock_prescale;
   int num_errors = 0, check_count = 0;
   utr_ctrl u_utr_ctrl (.clk(clk), .rst(rst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hsel(1'b1), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .tx_fill(tx_fill), .rx_fill(rx_fill), .fifo_ctrl_tx_trig(fifo_ctrl_tx_trig),
      .fifo_ctrl_rx_trig(fifo_ctrl_rx_trig),
      .tx_active(tx_active), .tx_shift_done(tx_shift_done), .bit_tick(bit_tick), .tx_irq_req(tx_irq_req),
      .rx_irq_req(rx_irq_req), .flow_stop_remote(flow_stop_remote), .clock_prescale(clock_prescale),
      .sample_rate(sample_rate), .rs485_mode(rs485_mode), .request_to_send_pin(request_to_send_pin),
      .terminal_ready_pin(terminal_ready_pin), .irq(irq));
   utr_far u_utr_far (.clk(clk), .rst(rst), .start(start), .tx_active(tx_active),
      .tx_shift_done(tx_shift_done), .bit_tick(bit_tick));
   always #25 clk = ~clk;
   // -----
   // helpers
   // -----
   task chk(input logic [31:0] a, input logic [31:0] e);
      check_count++;
      if (a !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, a, e);
      end
   endtask : chk
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask : wr
   task step;
      repeat (2) @(posedge clk);
      #1;
   endtask : step
   task lvl(input logic [7:0] a, input logic [7:0] v, input logic [7:0] f, input logic e);
      wr(a, {24'h00_0000, v});
      @(posedge clk);
      if (a == 8'h00) tx_fill <= f;
      else rx_fill <= f;
      step;
      chk(a == 8'h00 ? tx_irq_req : a == 8'h04 ? rx_irq_req : flow_stop_remote, e);
   endtask : lvl
   task frame(input logic [1:0] pins, input int n);
      int k;
      int t;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk({terminal_ready_pin, request_to_send_pin}, pins);
      k = 0;
      t = 0;
      while (tx_shift_done !== 1'b1 && k < 200) begin
         @(posedge clk);
         #1;
         k++;
      end
      // counts bit times from the last bit out until the driver lets go
      while ((request_to_send_pin | terminal_ready_pin) !== 1'b0 && k < 400) begin
         t += int'(bit_tick === 1'b1);
         @(posedge clk);
         #1;
         k++;
      end
      chk(32'(t), 32'(n));
   endtask : frame
   // -----
   // scenarios
   // -----
   task t_regs;
      logic [31:0] d;
      for (int i = 0; i < 7; i++) begin
         bus(8'(i * 4), 1'b0, 32'h0, d);
         chk(d, 32'h0);
         wr(8'(i * 4), 32'hffff_ffb0 + 32'(i));
         bus(8'(i * 4), 1'b0, 32'h0, d);
         chk(d, i == 4 ? 32'h4 : i == 5 ? 32'h1 : 32'hb0 + 32'(i));
      end
      chk(clock_prescale, 4'h4);
      chk(hresp, 1'b0);
      wr(8'h2c, 32'hffff_ffff);
      bus(8'h2c, 1'b0, 32'h0, d);
      chk(d, 32'h0);
      for (int c = 0; c < 4; c++) begin
         wr(8'h14, 32'(c));
         step;
         chk(sample_rate, c == 3 ? 2'b00 : 2'(c));
      end
   endtask : t_regs
   task t_levels;
      wr(8'h1c, 32'h4);
      lvl(8'h04, 8'h00, 8'h01, 1'b1);
      lvl(8'h04, 8'h00, 8'h00, 1'b0);
      lvl(8'h04, 8'h01, 8'h01, 1'b1);
      lvl(8'h04, 8'h40, 8'h3f, 1'b0);
      lvl(8'h04, 8'h40, 8'h40, 1'b1);
      lvl(8'h04, 8'hff, 8'h7f, 1'b0);
      lvl(8'h04, 8'h80, 8'h80, 1'b1);
      lvl(8'h00, 8'h10, 8'h0f, 1'b1);
      lvl(8'h00, 8'h10, 8'h10, 1'b0);
      wr(8'h1c, 32'h0);
      @(posedge clk);
      fifo_ctrl_rx_trig <= 2'b01;
      fifo_ctrl_tx_trig <= 2'b11;
      lvl(8'h04, 8'h00, 8'h0f, 1'b0);
      lvl(8'h04, 8'h00, 8'h10, 1'b1);
      lvl(8'h00, 8'h01, 8'h1b, 1'b1);
      lvl(8'h00, 8'h80, 8'h1c, 1'b0);
   endtask : t_levels
   task t_flow;
      wr(8'h1c, 32'h4);
      lvl(8'h0c, 8'h08, 8'h00, 1'b0);
      lvl(8'h08, 8'h20, 8'h1f, 1'b0);
      lvl(8'h08, 8'h20, 8'h20, 1'b1);
      lvl(8'h0c, 8'h08, 8'h09, 1'b1);
      lvl(8'h0c, 8'h08, 8'h08, 1'b0);
   endtask : t_flow
   task t_turn;
      logic [31:0] d;
      wr(8'h1c, 32'h2);
      step;
      chk(rs485_mode, 1'b0);
      frame(2'b00, 0);
      wr(8'h1c, 32'h3);
      step;
      chk(rs485_mode, 1'b1);
      wr(8'h18, 32'h3);
      wr(8'h28, 32'h8);
      bus(8'h24, 1'b0, 32'h0, d);
      frame(2'b10, 3);
      step;
      chk(irq, 1'b1);
      bus(8'h24, 1'b0, 32'h0, d);
      chk(d & 32'h8, 32'h8);
      step;
      chk(irq, 1'b0);
      wr(8'h28, 32'h0);
      wr(8'h1c, 32'h1);
      wr(8'h18, 32'h0);
      frame(2'b01, 0);
      step;
      chk(irq, 1'b0);
   endtask : t_turn
   task summarize;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_levels;
      t_flow;
      t_turn;
      summarize;
   end
   // the whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      summarize;
   end
endmodule : testbench

// ### sim/utr_ctrl_sva.sv
// assertion checker for the threshold, rate and turn-around block
`timescale 1ns/1ns
module utr_ctrl_sva #(
   parameter int FILL_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [FILL_W-1:0] tx_fill,
   input wire logic [FILL_W-1:0] rx_fill,
   input wire logic tx_active,
   input wire logic tx_irq_req,
   input wire logic rx_irq_req,
   input wire logic flow_stop_remote,
   input wire logic [1:0] sample_rate,
   input wire logic rs485_mode,
   input wire logic request_to_send_pin,
   input wire logic terminal_ready_pin
);
   // -----
   // properties
   // -----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // every level is at least one, at most 128, in either fifo mode
   a_rx_empty: assert property (rx_fill == 0 |=> !rx_irq_req)
      else $error("rx irq with empty fifo");
   a_rx_full: assert property (rx_fill >= 128 |=> rx_irq_req)
      else $error("no rx irq at full fifo");
   a_tx_empty: assert property (tx_fill == 0 |=> tx_irq_req)
      else $error("no tx irq at empty fifo");
   a_tx_full: assert property (tx_fill >= 128 |=> !tx_irq_req)
      else $error("tx irq at full fifo");
   a_flow_clear: assert property (rx_fill == 0 |=> !flow_stop_remote)
      else $error("flow stop with empty fifo");
   a_samp_legal: assert property (sample_rate != 2'b11)
      else $error("reserved sampling code out");
   a_dir_single: assert property (!(request_to_send_pin && terminal_ready_pin))
      else $error("both direction pins high");
   a_dir_drive: assert property (rs485_mode && tx_active |=> request_to_send_pin || terminal_ready_pin)
      else $error("driver not enabled in transmit");
   a_dir_drop: assert property ($fell(request_to_send_pin || terminal_ready_pin) |-> !$past(tx_active))
      else $error("driver released while sending");
endmodule : utr_ctrl_sva

bind utr_ctrl utr_ctrl_sva #(.FILL_W(FILL_W)) u_utr_ctrl_sva (.clk(clk), .rst(rst), .tx_fill(tx_fill),
   .rx_fill(rx_fill), .tx_active(tx_active), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req),
   .flow_stop_remote(flow_stop_remote), .sample_rate(sample_rate), .rs485_mode(rs485_mode),
   .request_to_send_pin(request_to_send_pin), .terminal_ready_pin(terminal_ready_pin));

// ### sim/utr_far.sv
// far side model: transmitter timing and bit clock
`timescale 1ns/1ns
module utr_far (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   output logic tx_active,
   output logic tx_shift_done,
   output logic bit_tick
);
   logic [1:0] ph_ff;
   logic [3:0] bits_ff;
   // four cycles a bit; done lands off the tick cycle so load and tick never meet
   always_ff @(posedge clk) begin
      ph_ff <= rst ? 2'b00 : ph_ff + 2'b01;
      bit_tick <= !rst && ph_ff == 2'b11;
      tx_shift_done <= 1'b0;
      if (rst) begin
         tx_active <= 1'b0;
      end else if (start) begin
         tx_active <= 1'b1;
         bits_ff <= 4'h9;
      end else if (tx_active && bit_tick) begin
         bits_ff <= bits_ff - 4'h1;
         tx_active <= bits_ff != 4'h0;
         tx_shift_done <= bits_ff == 4'h0;
      end
   end
endmodule : utr_far
